// >>> hw/bpt_pkg.sv
package bpt_pkg;

  // --------------------------------------------------------------------
  // backplane resources
  // --------------------------------------------------------------------
  localparam int SLOT_COUNT    = 14;
  localparam int BUSED_TRIGGER_LINE_LINES    = 12;
  localparam int LB_PAIRS      = 18;
  localparam int LB_MIN_PAIRS  = 18;
  localparam int LB_MID_PAIRS  = 42;
  localparam int LB_MAX_PAIRS  = 62;

  // --------------------------------------------------------------------
  // clocking
  // --------------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 10;
  localparam int REF_FREQ_MHZ   = 100;
  localparam int REF_TOL_PPM    = 100;
  localparam int DUTY_MIN_PCT   = 45;
  localparam int DUTY_MAX_PCT   = 50;
  // oe leads the first clock edge and trails the last one
  localparam int GUARD_TIME_NS  = 10;
  localparam int CNT_W          = 4;
  localparam logic [CNT_W-1:0] GUARD_CYCLES =
    CNT_W'((GUARD_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

  // --------------------------------------------------------------------
  // reset and drive levels
  // --------------------------------------------------------------------
  localparam logic DRV_OFF_LVL = 1'b0;
  localparam logic DRV_ON_LVL  = 1'b1;

  typedef enum logic [1:0] {
    DRV_IDLE  = 2'h0,
    DRV_LEAD  = 2'h1,
    DRV_RUN   = 2'h3,
    DRV_TRAIL = 2'h2
  } drv_state_e;

endpackage

// >>> hw/drv_if.sv
`timescale 1ns/1ps
interface drv_if;
  logic shmEnable;
  logic hostAllow;
  logic oe;
  logic clkHigh;
  logic active;

  modport gate (input shmEnable, input hostAllow, output oe, output clkHigh, output active);
  modport top  (output shmEnable, output hostAllow, input oe, input clkHigh, input active);
endinterface

// >>> hw/clock_driver_gate.sv
`timescale 1ns/1ps
module clock_driver_gate (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // driver group
  drv_if.gate       drv
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  typedef struct packed {
    logic                      meta;
    logic                      sync;
    bpt_pkg::drv_state_e       state;
    logic [bpt_pkg::CNT_W-1:0] cnt;
    logic                      oe;
    logic                      clkHigh;
    logic                      active;
  } gate_s;

  gate_s st;
  gate_s next_st;
  logic  allowed;

  assign allowed = st.sync && drv.hostAllow;

  always_comb begin
    next_st      = st;
    next_st.meta = drv.shmEnable;
    next_st.sync = st.meta;
    case (st.state)
      bpt_pkg::DRV_IDLE: begin
        if (allowed) begin
          next_st.state = bpt_pkg::DRV_LEAD;
          next_st.oe    = bpt_pkg::DRV_ON_LVL;
          next_st.cnt   = bpt_pkg::GUARD_CYCLES - bpt_pkg::CNT_ONE;
        end
      end
      bpt_pkg::DRV_LEAD: begin
        if (!allowed) begin
          next_st.state = bpt_pkg::DRV_IDLE;
          next_st.oe    = bpt_pkg::DRV_OFF_LVL;
        end else if (st.cnt == bpt_pkg::CNT_ZERO) begin
          // clock starts once the lead guard count has run out, authorisation still held
          next_st.state   = bpt_pkg::DRV_RUN;
          next_st.clkHigh = bpt_pkg::DRV_ON_LVL;
          next_st.active  = bpt_pkg::DRV_ON_LVL;
        end else begin
          next_st.cnt = st.cnt - bpt_pkg::CNT_ONE;
        end
      end
      bpt_pkg::DRV_RUN: begin
        if (!allowed) begin
          next_st.state   = bpt_pkg::DRV_TRAIL;
          next_st.clkHigh = bpt_pkg::DRV_OFF_LVL;
          next_st.active  = bpt_pkg::DRV_OFF_LVL;
          next_st.cnt     = bpt_pkg::GUARD_CYCLES - bpt_pkg::CNT_ONE;
        end
      end
      bpt_pkg::DRV_TRAIL: begin
        if (st.cnt == bpt_pkg::CNT_ZERO) begin
          next_st.state = bpt_pkg::DRV_IDLE;
          next_st.oe    = bpt_pkg::DRV_OFF_LVL;
        end else begin
          next_st.cnt = st.cnt - bpt_pkg::CNT_ONE;
        end
      end
      default: begin
        next_st = '0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign drv.oe      = st.oe;
  assign drv.clkHigh = st.clkHigh;
  assign drv.active  = st.active;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  a_oe_needs_auth: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(drv.oe) |-> $past(drv.shmEnable, 3) && $past(drv.hostAllow))
    else $error("driver enabled without authorisation");

  a_clk_prompt_start: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(drv.oe) && allowed |=> drv.clkHigh)
    else $error("clock did not start one cycle after oe");

  a_clk_under_oe: assert property (@(posedge mclk) disable iff (!rstn)
    drv.clkHigh |-> drv.oe)
    else $error("clock toggles while driver disabled");

  a_clk_prompt_stop: assert property (@(posedge mclk) disable iff (!rstn)
    drv.clkHigh && !allowed |=> !drv.clkHigh ##1 !drv.oe)
    else $error("clock or oe late to stop");

endmodule // clock_driver_gate

// >>> hw/backplane_clock_trigger_enable.sv
`timescale 1ns/1ps
module backplane_clock_trigger_enable (
  // clock and reset
  input  wire logic                           mclk,
  input  wire logic                           rstn,

  // shelf manager authorisations, asynchronous pins
  input  wire logic                           shmInstrClkEn,
  input  wire logic                           shmFabricClkEn,
  input  wire logic                           shmLocalBusEn,

  // host software controls
  input  wire logic                           hostInstrClkAllow,
  input  wire logic                           hostFabricClkAllow,
  input  wire logic                           hostLocalBusAllow,
  input  wire logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] hostTrigEn,
  input  wire logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] hostTrigData,
  input  wire logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] trigContentionClr,
  input  wire logic [bpt_pkg::LB_PAIRS-1:0]   lbTxData,

  // instrument reference clock driver
  output      logic                           instrument_ref_clock_oe,
  output      logic                           instrument_ref_clock_high,
  output      logic                           instrClkActive,

  // fabric reference clock driver
  output      logic                           fabric_ref_clock_oe,
  output      logic                           fabric_ref_clock_high,
  output      logic                           fabricClkActive,

  // bused trigger lines
  input  wire logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] bused_trigger_line_in,
  output      logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] bused_trigger_line_out,
  output      logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] bused_trigger_line_oe,
  output      logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] trigRx,
  output      logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] trigContention,

  // local bus port
  input  wire logic [bpt_pkg::LB_PAIRS-1:0]   lbIn,
  output      logic [bpt_pkg::LB_PAIRS-1:0]   lbOut,
  output      logic [bpt_pkg::LB_PAIRS-1:0]   lbOe,
  output      logic [bpt_pkg::LB_PAIRS-1:0]   lbRx,
  output      logic                           lbActive
);

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  // one enable bit spread over the whole local bus port
  function automatic logic [bpt_pkg::LB_PAIRS-1:0] spread_port(input logic en);
    spread_port = {bpt_pkg::LB_PAIRS{en}};
  endfunction

  // lines whose value held for three cycles
  function automatic logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] settled(
    input logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] v0,
    input logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] v1,
    input logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] v2
  );
    settled = ~(v0 ^ v1) & ~(v0 ^ v2);
  endfunction

  // --------------------------------------------------------------------
  // clock driver groups
  // --------------------------------------------------------------------
  drv_if instrDrv ();
  drv_if fabricDrv ();

  // each group sees only its own authorisation
  assign instrDrv.shmEnable  = shmInstrClkEn;
  assign instrDrv.hostAllow  = hostInstrClkAllow;
  assign fabricDrv.shmEnable = shmFabricClkEn;
  assign fabricDrv.hostAllow = hostFabricClkAllow;

  clock_driver_gate u_instr_gate (
    .mclk (mclk),
    .rstn (rstn),
    .drv  (instrDrv.gate)
  );

  clock_driver_gate u_fabric_gate (
    .mclk (mclk),
    .rstn (rstn),
    .drv  (fabricDrv.gate)
  );

  // high-phase data for an output ddr cell whose low phase is tied low:
  // mclk forwarded at 50 % duty, single backplane output
  assign instrument_ref_clock_oe   = instrDrv.oe;
  assign instrument_ref_clock_high = instrDrv.clkHigh;
  assign instrClkActive            = instrDrv.active;
  // same internal reference serves the fabric ports, fixed frequency
  assign fabric_ref_clock_oe       = fabricDrv.oe;
  assign fabric_ref_clock_high     = fabricDrv.clkHigh;
  assign fabricClkActive           = fabricDrv.active;

  // --------------------------------------------------------------------
  // trigger and local bus state
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] trigMeta;
    logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] trigSync;
    logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] trigOe;
    logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] trigOeD1;
    logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] trigOeD2;
    logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] trigOut;
    logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] trigOutD1;
    logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] trigOutD2;
    logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] trigContention;
    logic                           lbShmMeta;
    logic                           lbShmSync;
    logic                           lbActive;
    logic [bpt_pkg::LB_PAIRS-1:0]   lbOe;
    logic [bpt_pkg::LB_PAIRS-1:0]   lbOut;
    logic [bpt_pkg::LB_PAIRS-1:0]   lbMeta;
    logic [bpt_pkg::LB_PAIRS-1:0]   lbSync;
  } core_s;

  core_s                          st;
  core_s                          next_st;
  logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] trigSteady;
  logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] trigMismatch;
  logic                           lbAllowed;

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    next_st = st;

    // trigger receive path, two flops per line
    next_st.trigMeta = bused_trigger_line_in;
    next_st.trigSync = st.trigMeta;

    // drive only lines that software enabled
    next_st.trigOe  = hostTrigEn;
    next_st.trigOut = hostTrigData & hostTrigEn;

    // history to compare driven level against the synced pin
    next_st.trigOeD1  = st.trigOe;
    next_st.trigOeD2  = st.trigOeD1;
    next_st.trigOutD1 = st.trigOut;
    next_st.trigOutD2 = st.trigOutD1;

    trigSteady = st.trigOe & st.trigOeD1 & st.trigOeD2
               & settled(st.trigOut, st.trigOutD1, st.trigOutD2);
    trigMismatch = trigSteady & (st.trigSync ^ st.trigOutD2);

    // another module fights our line: sticky, set wins over clear
    next_st.trigContention = (st.trigContention & ~trigContentionClr) | trigMismatch;

    // local bus authorisation, two flops
    next_st.lbShmMeta = shmLocalBusEn;
    next_st.lbShmSync = st.lbShmMeta;
    lbAllowed         = st.lbShmSync && hostLocalBusAllow;

    // whole port switches together
    next_st.lbActive = lbAllowed;
    next_st.lbOe     = spread_port(lbAllowed);
    next_st.lbOut    = lbTxData & spread_port(lbAllowed);

    // local bus receive path
    next_st.lbMeta = lbIn;
    next_st.lbSync = st.lbMeta;
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign bused_trigger_line_out = st.trigOut;
  assign bused_trigger_line_oe  = st.trigOe;
  assign trigRx                 = st.trigSync;
  assign trigContention         = st.trigContention;
  assign lbOut                  = st.lbOut;
  assign lbOe                   = st.lbOe;
  assign lbRx                   = st.lbSync;
  assign lbActive               = st.lbActive;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  a_reset_all_off: assert property (@(posedge mclk)
    !rstn |=> (bused_trigger_line_oe == '0) && (lbOe == '0)
              && !instrument_ref_clock_oe && !fabric_ref_clock_oe)
    else $error("a driver is on after reset");

  a_bused_trigger_line_host_gate: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) |-> (bused_trigger_line_oe & ~$past(hostTrigEn)) == '0)
    else $error("trigger line driven without host enable");

  a_bused_trigger_line_follow_en: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) |-> bused_trigger_line_oe == $past(hostTrigEn))
    else $error("trigger enable not taken in one cycle");

  a_bused_trigger_line_quiet_low: assert property (@(posedge mclk) disable iff (!rstn)
    (bused_trigger_line_out & ~bused_trigger_line_oe) == '0)
    else $error("trigger data active on an undriven line");

  a_contention_sticky: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) |-> ($past(trigContention) & ~$past(trigContentionClr) & ~trigContention) == '0)
    else $error("contention flag lost without clear");

  a_lb_whole_port: assert property (@(posedge mclk) disable iff (!rstn)
    (lbOe == '0) || (lbOe == '1))
    else $error("local bus enabled pair by pair");

  a_lb_shm_first: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(lbOe[0]) |-> $past(shmLocalBusEn, 3) && $past(hostLocalBusAllow))
    else $error("local bus driven before shelf manager enable");

  a_lb_shm_drop: assert property (@(posedge mclk) disable iff (!rstn)
    !shmLocalBusEn [*3] |=> (lbOe == '0) && (lbOut == '0))
    else $error("local bus still driven after enable withdrawn");

  a_lb_width_fit: assert property (@(posedge mclk) disable iff (!rstn)
    bpt_pkg::LB_PAIRS == bpt_pkg::LB_MIN_PAIRS || bpt_pkg::LB_PAIRS == bpt_pkg::LB_MID_PAIRS
    || bpt_pkg::LB_PAIRS == bpt_pkg::LB_MAX_PAIRS)
    else $error("local bus width not a fitted size");

  a_clk_groups_apart: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(instrument_ref_clock_oe) |-> $past(shmInstrClkEn, 3))
    else $error("instrument clock enabled by another authorisation");

  a_fabric_apart: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(fabric_ref_clock_oe) |-> $past(shmFabricClkEn, 3))
    else $error("fabric clock enabled by another authorisation");

endmodule // backplane_clock_trigger_enable

// >>> verif/bpt_far_side.sv
`timescale 1ns/1ps
module bpt_far_side (
  // clock
  input  wire logic                           mclk,
  // scenario controls
  input  wire logic [2:0]                     shmReq,
  input  wire logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] peerTrigEn,
  input  wire logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] peerTrigData,
  input  wire logic                           peerLbEn,
  input  wire logic [bpt_pkg::LB_PAIRS-1:0]   peerLbData,
  // device drive
  input  wire logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] trigOe,
  input  wire logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] trigOut,
  // backplane pins
  output      logic                           shmInstrClkEn,
  output      logic                           shmFabricClkEn,
  output      logic                           shmLocalBusEn,
  output      logic [bpt_pkg::BUSED_TRIGGER_LINE_LINES-1:0] trigIn,
  output      logic [bpt_pkg::LB_PAIRS-1:0]   lbIn
);
  logic [2:0]                   shmPins = 3'h0;
  logic [bpt_pkg::LB_PAIRS-1:0] lbDrift = 18'h00000;

  // --------------------------------------------------------------------
  // shelf manager, pins move between clock edges
  // --------------------------------------------------------------------
  always @(shmReq) shmPins <= #3 shmReq;
  assign shmInstrClkEn  = shmPins[0];
  assign shmFabricClkEn = shmPins[1];
  assign shmLocalBusEn  = shmPins[2];

  // --------------------------------------------------------------------
  // other slots: peer wins a clash, idle trigger lines read 0, idle local bus toggles every cycle
  // --------------------------------------------------------------------
  assign trigIn = (peerTrigEn & peerTrigData) | (~peerTrigEn & trigOe & trigOut);
  always @(posedge mclk) lbDrift <= ~lbDrift;
  assign lbIn = peerLbEn ? peerLbData : lbDrift;
endmodule // bpt_far_side

// >>> verif/backplane_clock_trigger_enable_bench.sv
`timescale 1ns/1ps
module backplane_clock_trigger_enable_bench;
  localparam int TL      = bpt_pkg::BUSED_TRIGGER_LINE_LINES;
  localparam int LP      = bpt_pkg::LB_PAIRS;
  localparam int CEILING = 2000;

  // --------------------------------------------------------------------
  // pins
  // --------------------------------------------------------------------
  logic          mclk               = 1'b0;
  logic          rstn               = 1'b0;
  logic [2:0]    shmReq             = 3'h0;
  logic          hostInstrClkAllow  = 1'b0;
  logic          hostFabricClkAllow = 1'b0;
  logic          hostLocalBusAllow  = 1'b0;
  logic [TL-1:0] hostTrigEn         = 12'h000;
  logic [TL-1:0] hostTrigData       = 12'h000;
  logic [TL-1:0] trigContentionClr  = 12'h000;
  logic [TL-1:0] peerTrigEn         = 12'h000;
  logic [TL-1:0] peerTrigData       = 12'h000;
  logic [LP-1:0] lbTxData           = 18'h00000;
  logic [LP-1:0] peerLbData         = 18'h00000;
  logic          peerLbEn           = 1'b0;
  logic          shmInstrClkEn, shmFabricClkEn, shmLocalBusEn;
  logic          instrOe, instrHigh, instrAct, fabOe, fabHigh, fabAct, lbActive;
  logic [TL-1:0] trigIn, trigOut, trigOe, trigRx, trigCont;
  logic [LP-1:0] lbIn, lbOut, lbOe, lbRx;
  int            errTotal           = 0;
  int            nChecks            = 0;
  int            cycles             = 0;

  always #5 mclk = ~mclk;

  backplane_clock_trigger_enable i_backplane_clock_trigger_enable (
    .mclk(mclk), .rstn(rstn),
    .shmInstrClkEn(shmInstrClkEn), .shmFabricClkEn(shmFabricClkEn), .shmLocalBusEn(shmLocalBusEn),
    .hostInstrClkAllow(hostInstrClkAllow), .hostFabricClkAllow(hostFabricClkAllow),
    .hostLocalBusAllow(hostLocalBusAllow), .hostTrigEn(hostTrigEn), .hostTrigData(hostTrigData),
    .trigContentionClr(trigContentionClr), .lbTxData(lbTxData),
    .instrument_ref_clock_oe(instrOe), .instrument_ref_clock_high(instrHigh), .instrClkActive(instrAct),
    .fabric_ref_clock_oe(fabOe), .fabric_ref_clock_high(fabHigh), .fabricClkActive(fabAct),
    .bused_trigger_line_in(trigIn), .bused_trigger_line_out(trigOut), .bused_trigger_line_oe(trigOe),
    .trigRx(trigRx), .trigContention(trigCont),
    .lbIn(lbIn), .lbOut(lbOut), .lbOe(lbOe), .lbRx(lbRx), .lbActive(lbActive)
  );

  bpt_far_side i_bpt_far_side (
    .mclk(mclk), .shmReq(shmReq), .peerTrigEn(peerTrigEn), .peerTrigData(peerTrigData),
    .peerLbEn(peerLbEn), .peerLbData(peerLbData), .trigOe(trigOe), .trigOut(trigOut),
    .shmInstrClkEn(shmInstrClkEn), .shmFabricClkEn(shmFabricClkEn), .shmLocalBusEn(shmLocalBusEn),
    .trigIn(trigIn), .lbIn(lbIn)
  );

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic printVerdict;
    $display("checks %0d, mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic logic [63:0] grp(input int g);
    return (g == 0) ? 64'({instrOe, instrHigh, instrAct}) : 64'({fabOe, fabHigh, fabAct});
  endfunction

  task automatic setAllow(input int g, input logic v);
    if (g == 0) hostInstrClkAllow <= v;
    else hostFabricClkAllow <= v;
  endtask

  // oe, clock high, active as a 3-bit code
  task automatic clkGroup(input int g);
    @(posedge mclk);
    setAllow(g, 1'b1);
    repeat (5) @(posedge mclk);
    #1 check("clock group without shm", grp(g), 64'h0);
    @(posedge mclk);
    shmReq[g] <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 check("clock group early", grp(g), 64'h0);
    @(posedge mclk);
    #1 check("clock lead", grp(g), 64'h4);
    @(posedge mclk);
    #1 check("clock running", grp(g), 64'h7);
    check("other group idle", grp(1 - g), 64'h0);
    @(posedge mclk);
    setAllow(g, 1'b0);
    @(posedge mclk);
    #1 check("host off trail", grp(g), 64'h4);
    @(posedge mclk);
    #1 check("host off", grp(g), 64'h0);
    @(posedge mclk);
    setAllow(g, 1'b1);
    @(posedge mclk);
    #1 check("host on lead", grp(g), 64'h4);
    @(posedge mclk);
    shmReq[g] <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 check("shm off trail", grp(g), 64'h4);
    @(posedge mclk);
    #1 check("shm off", grp(g), 64'h0);
    setAllow(g, 1'b0);
  endtask

  // --------------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------------
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == CEILING) begin
      errTotal++;
      printVerdict();
    end
  end

  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 check("outputs after reset", 64'({instrOe, instrHigh, fabOe, fabHigh, trigOe, lbOe, lbActive}), 64'h0);
    clkGroup(0);
    clkGroup(1);
    for (int i = 0; i < TL; i++) begin
      @(posedge mclk);
      hostTrigEn   <= 12'h001 << i;
      hostTrigData <= 12'hfff;
      @(posedge mclk);
      #1 check("trigger oe", 64'(trigOe), 64'h1 << i);
      check("trigger out", 64'(trigOut), 64'h1 << i);
    end
    @(posedge mclk);
    hostTrigEn <= 12'h000;
    @(posedge mclk);
    #1 check("trigger released", 64'({trigOe, trigOut}), 64'h0);
    @(posedge mclk);
    hostTrigEn   <= 12'h008;
    hostTrigData <= 12'h000;
    peerTrigEn   <= 12'h008;
    peerTrigData <= 12'h008;
    repeat (6) @(posedge mclk);
    #1 check("trigger clash flag", 64'(trigCont), 64'h8);
    @(posedge mclk);
    peerTrigEn <= 12'h000;
    repeat (5) @(posedge mclk);
    trigContentionClr <= 12'h008;
    @(posedge mclk);
    trigContentionClr <= 12'h000;
    hostTrigEn        <= 12'h000;
    @(posedge mclk);
    #1 check("trigger clash cleared", 64'(trigCont), 64'h0);
    @(posedge mclk);
    hostLocalBusAllow <= 1'b1;
    lbTxData          <= 18'h2b3c1;
    peerLbEn          <= 1'b1;
    peerLbData        <= 18'h15a0f;
    repeat (5) @(posedge mclk);
    #1 check("local bus without shm", 64'({lbOe, lbActive, lbOut}), 64'h0);
    @(posedge mclk);
    shmReq[2] <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 check("local bus early", 64'({lbOe, lbActive}), 64'h0);
    @(posedge mclk);
    #1 check("local bus on", 64'({lbOe, lbActive, lbOut}), {27'h0, 18'h3ffff, 1'b1, 18'h2b3c1});
    check("local bus receive", 64'(lbRx), 64'h15a0f);
    @(posedge mclk);
    hostLocalBusAllow <= 1'b0;
    @(posedge mclk);
    #1 check("local bus off", 64'({lbOe, lbActive, lbOut}), 64'h0);
    printVerdict();
  end
endmodule // backplane_clock_trigger_enable_bench
